// >>> hdl/mpm_pkg.sv
// Package for the module power management pin block
package mpm_pkg;

  localparam int unsigned CLK_MHZ          = 250;
  // Debounce stable time in microseconds and derived cycle count
  localparam int unsigned DEBOUNCE_US      = 10;
  localparam int unsigned DEBOUNCE_CYC     = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned DEB_W            = 12;
  // Carrier reset stretch after module reset ends
  localparam int unsigned RST_HOLD_NS      = 1000;
  localparam int unsigned RST_HOLD_CYC     = RST_HOLD_NS * CLK_MHZ / 1000;
  localparam int unsigned HOLD_W           = 8;
  localparam logic        DEB_RESET_LEVEL  = 1'b1;

  typedef enum logic [1:0] {
    MPM_OFF     = 2'b00,
    MPM_RUN     = 2'b01,
    MPM_STANDBY = 2'b11
  } mpm_state_t;

  // Debounced carrier requests, active high
  typedef struct packed {
    logic power_button;
    logic sleep_req;
    logic lid_closed;
  } mpm_req_t;

  // Carrier status levels, active high
  typedef struct packed {
    logic battery_low;
    logic charging;
    logic charger_present;
    logic test_mode;
    logic mgmt_alert;
  } mpm_status_t;

  // Open-drain pin, oe low while the module drives
  typedef struct packed {
    logic o;
    logic oe_n;
  } mpm_od_t;

endpackage

// >>> hdl/mpm_debounce.sv
// Stable-time filter for one active-low carrier input
`timescale 1ns/1ns
module mpm_debounce #(
  parameter int unsigned STABLE_CYC = mpm_pkg::DEBOUNCE_CYC
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic raw,
  output logic      clean
);
  logic [mpm_pkg::DEB_W-1:0] cnt_ff;
  logic [mpm_pkg::DEB_W-1:0] nxt_cnt;
  logic                      clean_ff;
  logic                      nxt_clean;

  always_comb begin
    nxt_cnt   = cnt_ff;
    nxt_clean = clean_ff;
    if (raw == clean_ff) begin
      nxt_cnt = '0;
    end else if (cnt_ff >= mpm_pkg::DEB_W'(STABLE_CYC - 1)) begin
      nxt_clean = raw;
      nxt_cnt   = '0;
    end else begin
      nxt_cnt = cnt_ff + mpm_pkg::DEB_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff   <= '0;
      clean_ff <= mpm_pkg::DEB_RESET_LEVEL;
    end else begin
      cnt_ff   <= nxt_cnt;
      clean_ff <= nxt_clean;
    end
  end

  assign clean = clean_ff;
endmodule // mpm_debounce

// >>> hdl/mpm_power_pins.sv
// Power, reset and state management logic facing the carrier pins
// Contract
// - Supply fault low keeps module and carrier supplies disabled.
// - Carrier power grant asserted only when carrier circuits may power up.
// - Standby indicator low in standby state, high otherwise.
// - Reset request low forces module reset until released.
// - Power button active low, acts on the press edge, debounced.
// - Sleep request active low, level sensitive, debounced.
// - Lid low means closed, may start sleep; debounced.
// - Battery-low input low reports battery low.
// - Charging input low reports charging in progress.
// - Charger-present input low reports charger supply available.
// - Test functions active only while test input held low.
// - Management bus alert low is an interrupt request.
// - Power management link is open-drain I2C/SMBus data and clock.
// - Watchdog expiry driven only during runtime, else undriven.
// - Active-low reset output toward carrier circuits.
`timescale 1ns/1ns
module mpm_power_pins (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 supply_fault_in_n,
  input  wire logic                 reset_request_n,
  input  wire logic                 power_button_n,
  input  wire logic                 sleep_request_n,
  input  wire logic                 lid_n,
  input  wire logic                 battery_low_n,
  input  wire logic                 charging_n,
  input  wire logic                 charger_present_n,
  input  wire logic                 test_request_n,
  input  wire logic                 mgmt_bus_alert_n,
  input  wire logic                 wdt_expired,
  input  wire logic                 pm_bus_data_in,
  input  wire logic                 pm_bus_clock_in,
  input  wire logic                 pm_bus_data_drive_low,
  input  wire logic                 pm_bus_clock_drive_low,
  output logic                      carrier_power_grant,
  output logic                      module_supply_enable,
  output logic                      standby_indicator_n,
  output logic                      carrier_reset_n,
  output logic                      module_reset,
  output logic                      watchdog_expiry_n_o,
  output logic                      watchdog_expiry_n_oe_n,
  output logic                      pm_bus_data_o,
  output logic                      pm_bus_data_oe_n,
  output logic                      pm_bus_clock_o,
  output logic                      pm_bus_clock_oe_n,
  output logic                      pm_bus_data_rx,
  output logic                      pm_bus_clock_rx,
  output mpm_pkg::mpm_state_t       power_state,
  output mpm_pkg::mpm_req_t         requests,
  output mpm_pkg::mpm_status_t      status
);
  logic btn_clean;
  logic sleep_clean;
  logic lid_clean;

  mpm_debounce #(.STABLE_CYC(mpm_pkg::DEBOUNCE_CYC)) u_deb_btn (
    .clk   (clk),
    .rst   (rst),
    .raw   (power_button_n),
    .clean (btn_clean)
  );
  mpm_debounce #(.STABLE_CYC(mpm_pkg::DEBOUNCE_CYC)) u_deb_sleep (
    .clk   (clk),
    .rst   (rst),
    .raw   (sleep_request_n),
    .clean (sleep_clean)
  );
  mpm_debounce #(.STABLE_CYC(mpm_pkg::DEBOUNCE_CYC)) u_deb_lid (
    .clk   (clk),
    .rst   (rst),
    .raw   (lid_n),
    .clean (lid_clean)
  );

  // Request edge tracking for the power button
  logic                      btn_prev_ff;
  logic                      nxt_btn_prev;
  logic                      btn_press;
  mpm_pkg::mpm_state_t       state_ff;
  mpm_pkg::mpm_state_t       nxt_state;
  logic                      in_reset;
  logic                      fault;

  assign btn_press = btn_prev_ff && !btn_clean;
  assign fault     = !supply_fault_in_n;
  assign in_reset  = rst || !reset_request_n;
  assign nxt_btn_prev = btn_clean;

  // Button toggles on/off; sleep or lid close enters standby; button wakes
  always_comb begin
    nxt_state = state_ff;
    if (in_reset) begin
      nxt_state = mpm_pkg::MPM_OFF;
    end else if (fault) begin
      nxt_state = mpm_pkg::MPM_OFF;
    end else begin
      unique case (state_ff)
        mpm_pkg::MPM_OFF: begin
          if (btn_press) nxt_state = mpm_pkg::MPM_RUN;
        end
        mpm_pkg::MPM_RUN: begin
          if (btn_press) begin
            nxt_state = mpm_pkg::MPM_OFF;
          end else if (!sleep_clean || !lid_clean) begin
            nxt_state = mpm_pkg::MPM_STANDBY;
          end
        end
        mpm_pkg::MPM_STANDBY: begin
          // Button only; a closed lid would send it straight back to sleep
          if (btn_press) begin
            nxt_state = mpm_pkg::MPM_RUN;
          end
        end
        default: nxt_state = mpm_pkg::MPM_OFF;
      endcase
    end
  end

  // Reset stretch toward the carrier
  logic [mpm_pkg::HOLD_W-1:0] hold_ff;
  logic [mpm_pkg::HOLD_W-1:0] nxt_hold;
  always_comb begin
    if (in_reset) begin
      nxt_hold = mpm_pkg::HOLD_W'(mpm_pkg::RST_HOLD_CYC);
    end else if (hold_ff != '0) begin
      nxt_hold = hold_ff - mpm_pkg::HOLD_W'(1);
    end else begin
      nxt_hold = hold_ff;
    end
  end

  // Output next values
  logic                 nxt_grant;
  logic                 nxt_supply;
  logic                 nxt_stby_n;
  logic                 nxt_crst_n;
  logic                 nxt_mrst;
  logic                 nxt_wdt_oe_n;
  logic                 nxt_wdt_o;
  mpm_pkg::mpm_status_t nxt_status;
  mpm_pkg::mpm_req_t    nxt_req;
  logic                 running;

  assign running = (state_ff == mpm_pkg::MPM_RUN) && !in_reset && !fault;

  always_comb begin
    nxt_supply   = !fault && (state_ff != mpm_pkg::MPM_OFF);
    nxt_grant    = !fault && (state_ff == mpm_pkg::MPM_RUN);
    nxt_stby_n   = !(state_ff == mpm_pkg::MPM_STANDBY);
    nxt_mrst     = in_reset;
    nxt_crst_n   = !(in_reset || (hold_ff != '0));
    nxt_wdt_oe_n = !running;
    nxt_wdt_o    = !wdt_expired;
    nxt_status.battery_low     = !battery_low_n;
    nxt_status.charging        = !charging_n;
    nxt_status.charger_present = !charger_present_n;
    nxt_status.test_mode       = !test_request_n;
    nxt_status.mgmt_alert      = !mgmt_bus_alert_n;
    nxt_req.power_button = !btn_clean;
    nxt_req.sleep_req    = !sleep_clean;
    nxt_req.lid_closed   = !lid_clean;
  end

  // Open-drain bus pins: drive low only, float otherwise
  mpm_pkg::mpm_od_t nxt_dat;
  mpm_pkg::mpm_od_t nxt_clkp;
  always_comb begin
    nxt_dat.o     = 1'b0;
    nxt_dat.oe_n  = !pm_bus_data_drive_low;
    nxt_clkp.o    = 1'b0;
    nxt_clkp.oe_n = !pm_bus_clock_drive_low;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      btn_prev_ff            <= 1'b1;
      state_ff               <= mpm_pkg::MPM_OFF;
      hold_ff                <= mpm_pkg::HOLD_W'(mpm_pkg::RST_HOLD_CYC);
      carrier_power_grant    <= 1'b0;
      module_supply_enable   <= 1'b0;
      standby_indicator_n    <= 1'b1;
      carrier_reset_n        <= 1'b0;
      module_reset           <= 1'b1;
      watchdog_expiry_n_o    <= 1'b1;
      watchdog_expiry_n_oe_n <= 1'b1;
      pm_bus_data_o          <= 1'b0;
      pm_bus_data_oe_n       <= 1'b1;
      pm_bus_clock_o         <= 1'b0;
      pm_bus_clock_oe_n      <= 1'b1;
      pm_bus_data_rx         <= 1'b1;
      pm_bus_clock_rx        <= 1'b1;
      status                 <= '0;
      requests               <= '0;
    end else begin
      btn_prev_ff            <= nxt_btn_prev;
      state_ff               <= nxt_state;
      hold_ff                <= nxt_hold;
      carrier_power_grant    <= nxt_grant;
      module_supply_enable   <= nxt_supply;
      standby_indicator_n    <= nxt_stby_n;
      carrier_reset_n        <= nxt_crst_n;
      module_reset           <= nxt_mrst;
      watchdog_expiry_n_o    <= nxt_wdt_o;
      watchdog_expiry_n_oe_n <= nxt_wdt_oe_n;
      pm_bus_data_o          <= nxt_dat.o;
      pm_bus_data_oe_n       <= nxt_dat.oe_n;
      pm_bus_clock_o         <= nxt_clkp.o;
      pm_bus_clock_oe_n      <= nxt_clkp.oe_n;
      pm_bus_data_rx         <= pm_bus_data_in;
      pm_bus_clock_rx        <= pm_bus_clock_in;
      status                 <= nxt_status;
      requests               <= nxt_req;
    end
  end

  assign power_state = state_ff;
endmodule // mpm_power_pins

// >>> tb/mpm_chk.sv
// Pin-level assertions for the power management block
`timescale 1ns/1ns
module mpm_chk (
  input wire logic                 clk,
  input wire logic                 rst,
  input wire logic                 supply_fault_in_n,
  input wire logic                 reset_request_n,
  input wire logic                 power_button_n,
  input wire logic                 battery_low_n,
  input wire logic                 charging_n,
  input wire logic                 charger_present_n,
  input wire logic                 test_request_n,
  input wire logic                 mgmt_bus_alert_n,
  input wire logic                 wdt_expired,
  input wire logic                 pm_bus_data_drive_low,
  input wire logic                 pm_bus_data_o,
  input wire logic                 carrier_power_grant,
  input wire logic                 module_supply_enable,
  input wire logic                 standby_indicator_n,
  input wire logic                 carrier_reset_n,
  input wire logic                 module_reset,
  input wire logic                 watchdog_expiry_n_o,
  input wire logic                 watchdog_expiry_n_oe_n,
  input wire logic                 pm_bus_data_oe_n,
  input wire mpm_pkg::mpm_state_t  power_state,
  input wire mpm_pkg::mpm_req_t    requests,
  input wire mpm_pkg::mpm_status_t status
);
  logic [11:0] btn_lo_ff, rel_ff;
  // Saturating run lengths, wide enough for the debounce span
  always_ff @(posedge clk) begin
    btn_lo_ff <= power_button_n ? 12'h000 : btn_lo_ff + {11'h000, btn_lo_ff != 12'hFFF};
    rel_ff    <= module_reset ? 12'h000 : rel_ff + {11'h000, rel_ff != 12'hFFF};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  chk_fault_off: assert property (!supply_fault_in_n |-> ##2
    !carrier_power_grant && !module_supply_enable) else $error("supply on in fault");
  chk_grant_run: assert property (carrier_power_grant |->
    $past(power_state) == mpm_pkg::MPM_RUN) else $error("grant outside run");
  chk_stby_ind: assert property (!$past(rst) |-> standby_indicator_n ==
    ($past(power_state) != mpm_pkg::MPM_STANDBY)) else $error("standby level wrong");
  chk_req_reset: assert property (!reset_request_n |=> module_reset &&
    !carrier_reset_n && power_state == mpm_pkg::MPM_OFF) else $error("request ignored");
  chk_reset_out: assert property (module_reset |-> !carrier_reset_n)
    else $error("carrier reset released early");
  chk_reset_hold: assert property ($rose(carrier_reset_n) |->
    rel_ff >= 12'(mpm_pkg::RST_HOLD_CYC))
    else $error("carrier reset stretch short");
  chk_wdt_run: assert property (!watchdog_expiry_n_oe_n |->
    $past(power_state) == mpm_pkg::MPM_RUN && watchdog_expiry_n_o == !$past(wdt_expired))
    else $error("watchdog line driven wrongly");
  chk_status_map: assert property (!$past(rst) && $past(reset_request_n) |->
    status == mpm_pkg::mpm_status_t'(~$past({battery_low_n, charging_n, charger_present_n,
    test_request_n, mgmt_bus_alert_n}))) else $error("status mismatch");
  chk_bus_od: assert property (!$past(rst) |-> !pm_bus_data_o &&
    pm_bus_data_oe_n == !$past(pm_bus_data_drive_low)) else $error("bus drive wrong");
  chk_deb_press: assert property ($rose(requests.power_button) |->
    btn_lo_ff >= 12'(mpm_pkg::DEBOUNCE_CYC))
    else $error("button accepted too soon");
  cov_run: cover property ($rose(carrier_power_grant));
  cov_stby: cover property ($fell(standby_indicator_n));
  cov_fault: cover property (!supply_fault_in_n && $past(carrier_power_grant));
endmodule // mpm_chk
bind mpm_power_pins mpm_chk mpm_chk_i (.*);

// >>> tb/mpm_carrier.sv
// Carrier side: open-drain pullers against module pull-ups
`timescale 1ns/1ns
module mpm_carrier (
  input  wire logic [11:0] pull,
  input  wire logic        data_oe_n,
  input  wire logic        clock_oe_n,
  input  wire logic        wdt_o,
  input  wire logic        wdt_oe_n,
  output logic      [9:0]  level,
  output logic             data_wire,
  output logic             clock_wire,
  output logic             wdt_wire
);
  // Released lines float high through the pull-ups
  assign level = ~pull[9:0];
  assign data_wire = data_oe_n & ~pull[10];
  assign clock_wire = clock_oe_n & ~pull[11];
  // Undriven line sinks to its pull-down
  assign wdt_wire = wdt_oe_n ? 1'b0 : wdt_o;
endmodule // mpm_carrier

// >>> tb/mpm_power_pins_tb_top.sv
// Self-checking bench for the power management pin block
`timescale 1ns/1ns
module mpm_power_pins_tb_top;
  logic clk = 1'b0, rst = 1'b1, wdt_expired = 1'b0, dlo = 1'b0, clo = 1'b0;
  logic [11:0] pull = 12'h000;
  logic [9:0]  lvl;
  logic [31:0] r;
  logic dw, cw, ww, grant, sup, stby_n, crst_n, mrst, wo, woe_n, d_o, doe_n, c_o, coe_n;
  logic drx, crx;
  mpm_pkg::mpm_state_t  st;
  mpm_pkg::mpm_req_t    req;
  mpm_pkg::mpm_status_t sts;
  int num_errors = 0, n_tests = 0, est = 0, seed = 32'h6d563336;
  always #2 clk = ~clk;
  mpm_power_pins mpm_power_pins_i (.clk(clk), .rst(rst), .supply_fault_in_n(lvl[0]),
    .reset_request_n(lvl[1]), .power_button_n(lvl[2]), .sleep_request_n(lvl[3]),
    .lid_n(lvl[4]), .battery_low_n(lvl[5]), .charging_n(lvl[6]),
    .charger_present_n(lvl[7]), .test_request_n(lvl[8]), .mgmt_bus_alert_n(lvl[9]),
    .wdt_expired(wdt_expired), .pm_bus_data_in(dw), .pm_bus_clock_in(cw),
    .pm_bus_data_drive_low(dlo), .pm_bus_clock_drive_low(clo), .carrier_power_grant(grant),
    .module_supply_enable(sup), .standby_indicator_n(stby_n), .carrier_reset_n(crst_n),
    .module_reset(mrst), .watchdog_expiry_n_o(wo), .watchdog_expiry_n_oe_n(woe_n),
    .pm_bus_data_o(d_o), .pm_bus_data_oe_n(doe_n), .pm_bus_clock_o(c_o),
    .pm_bus_clock_oe_n(coe_n), .pm_bus_data_rx(drx), .pm_bus_clock_rx(crx),
    .power_state(st), .requests(req), .status(sts));
  mpm_carrier mpm_carrier_i (.pull(pull), .data_oe_n(doe_n), .clock_oe_n(coe_n),
    .wdt_o(wo), .wdt_oe_n(woe_n), .level(lvl), .data_wire(dw), .clock_wire(cw),
    .wdt_wire(ww));
  task automatic note(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Model: est 0 off, 1 run, 3 standby; cr is {carrier reset_n, module reset}
  task automatic cmp_pins(input logic [1:0] cr);
    note({5'h00, st, grant, sup, stby_n, crst_n, mrst, ww, req}, {5'h00, est[1:0], est == 1,
      est != 0, est != 3, cr, (est == 1) & !wdt_expired, pull[2], pull[3], pull[4]});
  endtask
  task automatic cmp_stat();
    note({5'h00, sts, doe_n, coe_n, drx, crx, d_o, c_o}, {5'h00, pull[5], pull[6], pull[7],
      pull[8], pull[9], !dlo, !clo, !(dlo | pull[10]), !(clo | pull[11]), 2'b00});
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Long enough for the debounce to settle
  task automatic hold(input int b, input logic v);
    pull[b] = v;
    tick(2600);
  endtask
  task automatic press();
    hold(2, 1'b1);
    hold(2, 1'b0);
    est = (est == 1) ? 0 : 1;
  endtask
  task automatic end_of_test();
    if (num_errors == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    end_of_test();
  end
  initial begin
    tick(10);
    rst = 1'b0;
    tick(2);
    cmp_pins(2'b00);
    tick(300);
    cmp_pins(2'b10);
    repeat (40) begin
      r = $random(seed);
      pull[11:5] = r[6:0];
      {dlo, clo, wdt_expired} = r[10:8];
      tick(4);
      cmp_stat();
    end
    pull[11:5] = 7'h00;
    press();
    cmp_pins(2'b10);
    wdt_expired = ~wdt_expired;
    tick(3);
    cmp_pins(2'b10);
    pull[3] = 1'b1;
    tick(100);
    hold(3, 1'b0);
    cmp_pins(2'b10);
    hold(3, 1'b1);
    est = 3;
    cmp_pins(2'b10);
    hold(3, 1'b0);
    press();
    cmp_pins(2'b10);
    pull[0] = 1'b1;
    tick(3);
    est = 0;
    cmp_pins(2'b10);
    pull[0] = 1'b0;
    tick(3);
    cmp_pins(2'b10);
    press();
    cmp_pins(2'b10);
    pull[1] = 1'b1;
    tick(3);
    est = 0;
    cmp_pins(2'b01);
    pull[1] = 1'b0;
    tick(3);
    cmp_pins(2'b00);
    tick(300);
    cmp_pins(2'b10);
    hold(4, 1'b1);
    cmp_pins(2'b10);
    hold(4, 1'b0);
    press();
    hold(4, 1'b1);
    est = 3;
    cmp_pins(2'b10);
    hold(4, 1'b0);
    cmp_pins(2'b10);
    end_of_test();
  end
endmodule // mpm_power_pins_tb_top
